/* verilog/tzs_map.vh */
// register map, field layout, reset values and protocol codes
`ifndef TZS_MAP_VH
`define TZS_MAP_VH
// ==========================================================
// register selections
`define TZS_REG_LOCAL_RESULT 8'h00
`define TZS_REG_CONTROL 8'h01
`define TZS_REG_LOCAL_HYST 8'h02
`define TZS_REG_LOCAL_SET 8'h03
`define TZS_REG_REMOTE_RESULT 8'h10
`define TZS_REG_REMOTE_HYST 8'h12
`define TZS_REG_REMOTE_SET 8'h13
`define TZS_REG_OT_RELEASE 8'h22
`define TZS_REG_OT_TRIP 8'h23
// ==========================================================
// control register fields
`define TZS_BIT_SHUTDOWN 0
`define TZS_BIT_MODE 1
`define TZS_BIT_MASK 2
`define TZS_FQ_LO 3
`define TZS_FQ_HI 4
`define TZS_BIT_LOCAL_ST 5
`define TZS_BIT_REMOTE_ST 6
`define TZS_BIT_OT_ST 7
`define TZS_CTRL_WMASK 8'h1F
// ==========================================================
// reset values
`define TZS_RST_CTRL 5'h00
`define TZS_RST_RESULT 8'h00
`define TZS_RST_LOCAL_HYST 8'h4C
`define TZS_RST_LOCAL_SET 8'h51
`define TZS_RST_REMOTE_HYST 8'h5C
`define TZS_RST_REMOTE_SET 8'h61
`define TZS_RST_OT_RELEASE 8'h5C
`define TZS_RST_OT_TRIP 8'h61
`define TZS_FULL_SCALE 8'h7F
// ==========================================================
// slave address and queue depths
`define TZS_ADDR_HI 6'h24
`define TZS_FQ_D0 3'h1
`define TZS_FQ_D1 3'h2
`define TZS_FQ_D2 3'h4
`define TZS_FQ_D3 3'h6
// ==========================================================
// local conversion time and clock period in ns
`define TZS_LOCAL_CONV_NS 40000
`define TZS_CLK_PERIOD_NS 5
`endif

/* verilog/tzs_filter.v */
// fault-queue filter: counts consecutive qualifying conversions
`timescale 1ns/100ps
`default_nettype none
module tzs_filter (
  // clock and reset
  input wire clock,
  input wire resetn,
  // evaluation strobe and conditions
  input wire eval,
  input wire cond_hi,
  input wire cond_lo,
  input wire [2:0] depth,
  // filtered results, one-cycle pulses
  output reg hit_hi,
  output reg hit_lo
);
  reg [2:0] cnt_hi;
  reg [2:0] cnt_lo;
  wire [2:0] inc_hi = cnt_hi + 3'h1;
  wire [2:0] inc_lo = cnt_lo + 3'h1;

  // ==========================================================
  // consecutive run counters
  always @(posedge clock) begin
    if (!resetn) begin
      cnt_hi <= 3'h0;
      cnt_lo <= 3'h0;
      hit_hi <= 1'b0;
      hit_lo <= 1'b0;
    end else begin
      hit_hi <= 1'b0;
      hit_lo <= 1'b0;
      if (eval) begin
        cnt_hi <= cond_hi ? ((inc_hi >= depth) ? depth : inc_hi) : 3'h0;
        cnt_lo <= cond_lo ? ((inc_lo >= depth) ? depth : inc_lo) : 3'h0;
        hit_hi <= cond_hi && (inc_hi >= depth);
        hit_lo <= cond_lo && (inc_lo >= depth);
      end
    end
  end
endmodule
`default_nettype wire

/* verilog/tzs_supervisor.v */
// two-zone thermal supervisor: serial slave, sequencer, alarms
`timescale 1ns/100ps
`default_nettype none
`include "tzs_map.vh"
module tzs_supervisor #(
  parameter LOCAL_CONV_CYCLES =
    `TZS_LOCAL_CONV_NS / `TZS_CLK_PERIOD_NS,
  parameter REMOTE_CONV_CYCLES = 2 * LOCAL_CONV_CYCLES
) (
  // clock and reset
  input wire clock,
  input wire resetn,
  // two-wire bus pins
  input wire bus_clk,
  input wire bus_data_in,
  output wire bus_data_out,
  output wire bus_data_oe,
  // strap
  input wire address_select_input,
  // analog front end results
  input wire [7:0] local_adc_value,
  input wire [7:0] remote_adc_value,
  input wire remote_sense_fault,
  // alarm pins, open drain low active
  output wire alarm_out_n,
  output wire alarm_oe,
  output wire overtemp_out_n,
  output wire overtemp_oe,
  // conversion status
  output reg converting_remote,
  output reg conv_busy
);
  // ==========================================================
  // pin synchronisers: three stages, second and third agree
  reg [2:0] scl_sync;
  reg [2:0] sda_sync;
  reg scl;
  reg sda;
  always @(posedge clock) begin
    if (!resetn) begin
      scl_sync <= 3'h7;
      sda_sync <= 3'h7;
      scl <= 1'b1;
      sda <= 1'b1;
    end else begin
      scl_sync <= {scl_sync[1:0], bus_clk};
      sda_sync <= {sda_sync[1:0], bus_data_in};
      if (scl_sync[1] == scl_sync[2])
        scl <= scl_sync[2];
      if (sda_sync[1] == sda_sync[2])
        sda <= sda_sync[2];
    end
  end
  reg scl_d;
  reg sda_d;
  always @(posedge clock) begin
    if (!resetn) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_d <= scl;
      sda_d <= sda;
    end
  end
  wire scl_rise = scl & ~scl_d;
  wire scl_fall = ~scl & scl_d;
  wire start_cond = scl & scl_d & sda_d & ~sda;
  wire stop_cond = scl & scl_d & ~sda_d & sda;

  // ==========================================================
  // registers
  reg [4:0] ctrl;
  reg [7:0] local_result;
  reg [7:0] remote_result;
  reg [7:0] local_hysteresis;
  reg [7:0] local_setpoint;
  reg [7:0] remote_hysteresis;
  reg [7:0] remote_setpoint;
  reg [7:0] overtemp_release_threshold;
  reg [7:0] overtemp_trip_threshold;
  reg local_zone_status;
  reg remote_zone_status;
  reg overtemp_status;
  reg [7:0] pointer;
  reg addr_lsb;
  reg strap_done;
  wire shutdown = ctrl[`TZS_BIT_SHUTDOWN];
  wire int_mode = ctrl[`TZS_BIT_MODE];
  wire alarm_mask_bit = ctrl[`TZS_BIT_MASK];
  wire [1:0] fq_field = ctrl[`TZS_FQ_HI:`TZS_FQ_LO];

  // queue depth decode
  function [2:0] fq_depth;
    input [1:0] code;
    begin
      case (code)
        2'h0: fq_depth = `TZS_FQ_D0;
        2'h1: fq_depth = `TZS_FQ_D1;
        2'h2: fq_depth = `TZS_FQ_D2;
        default: fq_depth = `TZS_FQ_D3;
      endcase
    end
  endfunction
  wire [2:0] depth = fq_depth(fq_field);

  // register read decode
  function [7:0] reg_read;
    input [7:0] sel;
    input [7:0] status_byte;
    begin
      case (sel)
        `TZS_REG_LOCAL_RESULT: reg_read = local_result;
        `TZS_REG_CONTROL: reg_read = status_byte;
        `TZS_REG_LOCAL_HYST: reg_read = local_hysteresis;
        `TZS_REG_LOCAL_SET: reg_read = local_setpoint;
        `TZS_REG_REMOTE_RESULT: reg_read = remote_result;
        `TZS_REG_REMOTE_HYST: reg_read = remote_hysteresis;
        `TZS_REG_REMOTE_SET: reg_read = remote_setpoint;
        `TZS_REG_OT_RELEASE: reg_read = overtemp_release_threshold;
        `TZS_REG_OT_TRIP: reg_read = overtemp_trip_threshold;
        default: reg_read = 8'h00;
      endcase
    end
  endfunction
  wire [7:0] status_byte = {overtemp_status, remote_zone_status,
                            local_zone_status, ctrl};
  wire [7:0] read_byte = reg_read(pointer, status_byte);

  // ==========================================================
  // serial slave
  localparam S_IDLE = 3'h0;
  localparam S_ADDR = 3'h1;
  localparam S_ACK = 3'h2;
  localparam S_RX = 3'h3;
  localparam S_TX = 3'h4;
  localparam S_MACK = 3'h5;
  reg [2:0] state;
  reg [2:0] bitcnt;
  reg [7:0] shreg;
  reg rw;
  reg [1:0] bytes_rx;
  reg drive_low;
  reg active;
  reg wr_strobe;
  reg rd_strobe;
  reg [7:0] wr_data;
  reg ack_next;
  always @(posedge clock) begin
    if (!resetn) begin
      state <= S_IDLE;
      bitcnt <= 3'h0;
      shreg <= 8'h00;
      rw <= 1'b0;
      bytes_rx <= 2'h0;
      drive_low <= 1'b0;
      active <= 1'b0;
      pointer <= `TZS_REG_LOCAL_RESULT;
      wr_strobe <= 1'b0;
      rd_strobe <= 1'b0;
      wr_data <= 8'h00;
      ack_next <= 1'b0;
    end else begin
      wr_strobe <= 1'b0;
      rd_strobe <= 1'b0;
      if (start_cond) begin
        state <= S_ADDR;
        bitcnt <= 3'h0;
        bytes_rx <= 2'h0;
        drive_low <= 1'b0;
      end else if (stop_cond) begin
        state <= S_IDLE;
        drive_low <= 1'b0;
        active <= 1'b0;
      end else begin
        case (state)
          S_IDLE: drive_low <= 1'b0;
          S_ADDR, S_RX: begin
            if (scl_rise) begin
              shreg <= {shreg[6:0], sda};
              bitcnt <= bitcnt + 3'h1;
              if (bitcnt == 3'h7)
                ack_next <= 1'b1;
            end
            if (scl_fall && ack_next) begin
              ack_next <= 1'b0;
              if (state == S_ADDR) begin
                if (shreg[7:1] == {`TZS_ADDR_HI, addr_lsb}) begin
                  rw <= shreg[0];
                  active <= 1'b1;
                  drive_low <= 1'b1;
                  state <= S_ACK;
                end else begin
                  state <= S_IDLE;
                end
              end else begin
                drive_low <= 1'b1;
                state <= S_ACK;
                if (bytes_rx == 2'h0)
                  pointer <= shreg;
                else begin
                  wr_data <= shreg;
                  wr_strobe <= 1'b1;
                end
                bytes_rx <= (bytes_rx == 2'h2) ? 2'h2 : bytes_rx + 2'h1;
              end
            end
          end
          S_ACK: begin
            if (scl_fall) begin
              bitcnt <= 3'h0;
              if (rw) begin
                shreg <= read_byte;
                drive_low <= ~read_byte[7];
                rd_strobe <= 1'b1;
                state <= S_TX;
              end else begin
                drive_low <= 1'b0;
                state <= S_RX;
              end
            end
          end
          S_TX: begin
            if (scl_fall) begin
              bitcnt <= bitcnt + 3'h1;
              if (bitcnt == 3'h7) begin
                drive_low <= 1'b0;
                state <= S_MACK;
              end else begin
                drive_low <= ~shreg[6];
                shreg <= {shreg[6:0], 1'b0};
              end
            end
          end
          S_MACK: begin
            if (scl_rise)
              state <= sda ? S_IDLE : S_ACK;
          end
          default: state <= S_IDLE;
        endcase
      end
    end
  end
  assign bus_data_out = 1'b0;
  assign bus_data_oe = drive_low;
  wire ctrl_read = rd_strobe && (pointer == `TZS_REG_CONTROL);

  // ==========================================================
  // strap capture once after reset release
  always @(posedge clock) begin
    if (!resetn) begin
      strap_done <= 1'b0;
      addr_lsb <= 1'b0;
    end else if (!strap_done) begin
      strap_done <= 1'b1;
      addr_lsb <= address_select_input;
    end
  end

  // ==========================================================
  // conversion sequencer
  localparam CW = 20;
  reg [CW-1:0] conv_cnt;
  reg local_done;
  reg remote_done;
  wire [CW-1:0] local_len = LOCAL_CONV_CYCLES[CW-1:0];
  wire [CW-1:0] remote_len = REMOTE_CONV_CYCLES[CW-1:0];
  wire conv_hold = shutdown | active;
  always @(posedge clock) begin
    if (!resetn) begin
      conv_cnt <= {CW{1'b0}};
      converting_remote <= 1'b1;
      conv_busy <= 1'b0;
      local_done <= 1'b0;
      remote_done <= 1'b0;
    end else begin
      local_done <= 1'b0;
      remote_done <= 1'b0;
      if (conv_hold) begin
        // partial result dropped; same zone restarts after bus access, remote zone after shutdown
        conv_cnt <= {CW{1'b0}};
        conv_busy <= 1'b0;
        if (shutdown)
          converting_remote <= 1'b1;
      end else begin
        conv_busy <= 1'b1;
        if (conv_cnt + 20'h1 >=
            (converting_remote ? remote_len : local_len)) begin
          conv_cnt <= {CW{1'b0}};
          remote_done <= converting_remote;
          local_done <= ~converting_remote;
          converting_remote <= ~converting_remote;
        end else begin
          conv_cnt <= conv_cnt + 20'h1;
        end
      end
    end
  end

  // ==========================================================
  // result and threshold registers
  always @(posedge clock) begin
    if (!resetn) begin
      ctrl <= `TZS_RST_CTRL;
      local_result <= `TZS_RST_RESULT;
      remote_result <= `TZS_RST_RESULT;
      local_hysteresis <= `TZS_RST_LOCAL_HYST;
      local_setpoint <= `TZS_RST_LOCAL_SET;
      remote_hysteresis <= `TZS_RST_REMOTE_HYST;
      remote_setpoint <= `TZS_RST_REMOTE_SET;
      overtemp_release_threshold <= `TZS_RST_OT_RELEASE;
      overtemp_trip_threshold <= `TZS_RST_OT_TRIP;
    end else begin
      if (local_done)
        local_result <= local_adc_value;
      if (remote_done)
        remote_result <= remote_sense_fault ? `TZS_FULL_SCALE
                                            : remote_adc_value;
      if (wr_strobe) begin
        case (pointer)
          `TZS_REG_CONTROL: ctrl <= wr_data[4:0];
          `TZS_REG_LOCAL_HYST: local_hysteresis <= wr_data;
          `TZS_REG_LOCAL_SET: local_setpoint <= wr_data;
          `TZS_REG_REMOTE_HYST: remote_hysteresis <= wr_data;
          `TZS_REG_REMOTE_SET: remote_setpoint <= wr_data;
          `TZS_REG_OT_RELEASE: overtemp_release_threshold <= wr_data;
          `TZS_REG_OT_TRIP: overtemp_trip_threshold <= wr_data;
          default: ctrl <= ctrl;
        endcase
      end
    end
  end

  // ==========================================================
  // evaluation one cycle after the result lands
  reg local_eval;
  reg remote_eval;
  always @(posedge clock) begin
    if (!resetn) begin
      local_eval <= 1'b0;
      remote_eval <= 1'b0;
    end else begin
      local_eval <= local_done;
      remote_eval <= remote_done;
    end
  end
  wire l_hi;
  wire l_lo;
  wire r_hi;
  wire r_lo;
  wire o_hi;
  wire o_lo;
  // fault detection runs through the remote filter
  tzs_filter u_local (.clock(clock), .resetn(resetn),
    .eval(local_eval),
    .cond_hi($signed(local_result) > $signed(local_setpoint)),
    .cond_lo($signed(local_result) < $signed(local_hysteresis)),
    .depth(depth), .hit_hi(l_hi), .hit_lo(l_lo));
  tzs_filter u_remote (.clock(clock), .resetn(resetn),
    .eval(remote_eval),
    .cond_hi($signed(remote_result) > $signed(remote_setpoint)),
    .cond_lo($signed(remote_result) < $signed(remote_hysteresis)),
    .depth(depth), .hit_hi(r_hi), .hit_lo(r_lo));
  tzs_filter u_ot (.clock(clock), .resetn(resetn),
    .eval(remote_eval),
    .cond_hi($signed(remote_result) >
             $signed(overtemp_trip_threshold)),
    .cond_lo($signed(remote_result) <
             $signed(overtemp_release_threshold)),
    .depth(depth), .hit_hi(o_hi), .hit_lo(o_lo));

  // ==========================================================
  // zone status and alarm logic
  reg local_over;
  reg remote_over;
  reg alarm;
  reg shutdown_d;
  wire enter_shutdown_control_bit = shutdown & ~shutdown_d;
  always @(posedge clock) begin
    if (!resetn) begin
      local_zone_status <= 1'b0;
      remote_zone_status <= 1'b0;
      overtemp_status <= 1'b0;
      local_over <= 1'b0;
      remote_over <= 1'b0;
      alarm <= 1'b0;
      shutdown_d <= 1'b0;
    end else begin
      shutdown_d <= shutdown;
      if (o_hi)
        overtemp_status <= 1'b1;
      else if (o_lo)
        overtemp_status <= 1'b0;
      if (!int_mode) begin
        if (l_hi) local_zone_status <= 1'b1;
        else if (l_lo) local_zone_status <= 1'b0;
        else if (ctrl_read) local_zone_status <= 1'b0;
        if (r_hi) remote_zone_status <= 1'b1;
        else if (r_lo) remote_zone_status <= 1'b0;
        else if (ctrl_read) remote_zone_status <= 1'b0;
        if (l_hi) local_over <= 1'b1;
        else if (l_lo) local_over <= 1'b0;
        if (r_hi) remote_over <= 1'b1;
        else if (r_lo) remote_over <= 1'b0;
        alarm <= (l_hi | (local_over & ~l_lo)) |
                 (r_hi | (remote_over & ~r_lo));
      end else if (enter_shutdown_control_bit) begin
        local_zone_status <= 1'b0;
        remote_zone_status <= 1'b0;
        alarm <= 1'b0;
      end else begin
        // alternating events, set wins over read clear
        if ((l_hi & ~local_over) | (l_lo & local_over)) begin
          local_over <= ~local_over;
          local_zone_status <= 1'b1;
        end else if (ctrl_read)
          local_zone_status <= 1'b0;
        if ((r_hi & ~remote_over) | (r_lo & remote_over)) begin
          remote_over <= ~remote_over;
          remote_zone_status <= 1'b1;
        end else if (ctrl_read)
          remote_zone_status <= 1'b0;
        if ((l_hi & ~local_over) | (l_lo & local_over) |
            (r_hi & ~remote_over) | (r_lo & remote_over))
          alarm <= 1'b1;
        else if (rd_strobe)
          alarm <= 1'b0;
      end
    end
  end
  assign alarm_oe = alarm & ~alarm_mask_bit;
  assign alarm_out_n = 1'b0;
  assign overtemp_oe = overtemp_status;
  assign overtemp_out_n = 1'b0;
endmodule
`default_nettype wire

/* test/tzs_host.sv */
// behavioural two-wire bus host driving the supervisor pins
`timescale 1ns/100ps
`default_nettype none
module tzs_host (
  // clock
  input wire logic clock,
  // two-wire pins
  input wire logic sda,
  output logic scl,
  output logic sda_oe
);
  // bus clock stands high outside frames
  initial begin
    scl = 1'b1;
    sda_oe = 1'b0;
  end
  // half of the 80 ns bus clock period
  task hw;
    repeat (8) @(negedge clock);
  endtask
  // start, also used as repeated start
  task start;
    sda_oe = 1'b0;
    hw;
    scl = 1'b1;
    hw;
    sda_oe = 1'b1;
    hw;
    scl = 1'b0;
  endtask
  task stop;
    sda_oe = 1'b1;
    hw;
    scl = 1'b1;
    hw;
    sda_oe = 1'b0;
    hw;
  endtask
  // data set while clock low, sampled just before the fall
  task bitx(input logic b, output logic r);
    sda_oe = ~b;
    hw;
    scl = 1'b1;
    hw;
    r = sda;
    scl = 1'b0;
  endtask
  // eight bits msb first, then the acknowledge slot
  task xfer(input logic [7:0] d, input logic a, output logic [7:0] q,
            output logic k);
    for (int i = 7; i >= 0; i--) bitx(d[i], q[i]);
    bitx(a, k);
  endtask
  // only the nine defined selections are sent as commands
  task wr(input logic [6:0] ad, input logic [7:0] c, input logic [7:0] d,
          output logic k);
    logic [7:0] q;
    logic k1, k2, k3;
    start;
    xfer({ad, 1'b0}, 1'b1, q, k1);
    xfer(c, 1'b1, q, k2);
    xfer(d, 1'b1, q, k3);
    stop;
    k = k1 | k2 | k3;
  endtask
  task rd(input logic [6:0] ad, input logic [7:0] c, output logic [7:0] q,
          output logic k);
    logic [7:0] x;
    logic k1, k2, k3;
    start;
    xfer({ad, 1'b0}, 1'b1, x, k1);
    xfer(c, 1'b1, x, k2);
    start;
    xfer({ad, 1'b1}, 1'b1, x, k3);
    xfer(8'hFF, 1'b1, q, k);
    stop;
    k = k1 | k2 | k3;
  endtask
  task rx(input logic [6:0] ad, output logic [7:0] q, output logic k);
    logic [7:0] x;
    logic n;
    start;
    xfer({ad, 1'b1}, 1'b1, x, k);
    xfer(8'hFF, 1'b1, q, n);
    stop;
  endtask
endmodule
`default_nettype wire

/* test/tzs_properties.sv */
// checker of timing relations at the supervisor pins
`timescale 1ns/100ps
`default_nettype none
module tzs_props #(
  parameter LOCAL_CONV_CYCLES = 20,
  parameter REMOTE_CONV_CYCLES = 40
) (
  // clock and reset
  input wire logic clock,
  input wire logic resetn,
  // bus pins
  input wire logic bus_clk,
  input wire logic bus_data_out,
  input wire logic bus_data_oe,
  // alarm pins
  input wire logic alarm_out_n,
  input wire logic alarm_oe,
  input wire logic overtemp_out_n,
  input wire logic overtemp_oe,
  // conversion status
  input wire logic converting_remote,
  input wire logic conv_busy
);
  // ==========================================================
  // helper counters
  int run_cnt;
  int idle_cnt;
  logic zone_q;
  always @(posedge clock) begin
    zone_q <= converting_remote;
    if (!conv_busy || zone_q != converting_remote)
      run_cnt <= 0;
    else
      run_cnt <= run_cnt + 1;
    idle_cnt <= conv_busy ? 0 : (idle_cnt > 7 ? 8 : idle_cnt + 1);
  end
  // ==========================================================
  // properties
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  property p_reset_quiet;
    $rose(resetn) |-> !alarm_oe && !overtemp_oe && !bus_data_oe && !conv_busy;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet)
    else $error("output active right after reset");
  property p_local_len;
    conv_busy && $past(conv_busy) && $rose(converting_remote) |->
      run_cnt >= LOCAL_CONV_CYCLES - 2 && run_cnt <= LOCAL_CONV_CYCLES + 1;
  endproperty
  a_local_len: assert property (p_local_len)
    else $error("local conversion length wrong");
  property p_remote_len;
    conv_busy && $past(conv_busy) && $fell(converting_remote) |->
      run_cnt >= REMOTE_CONV_CYCLES - 2 && run_cnt <= REMOTE_CONV_CYCLES + 1;
  endproperty
  a_remote_len: assert property (p_remote_len)
    else $error("remote conversion length wrong");
  property p_ot_frozen;
    idle_cnt > 4 |-> $stable(overtemp_oe);
  endproperty
  a_ot_frozen: assert property (p_ot_frozen)
    else $error("overtemp changed with converter stopped");
  property p_ot_zone;
    $changed(overtemp_oe) |-> !converting_remote;
  endproperty
  a_ot_zone: assert property (p_ot_zone)
    else $error("overtemp changed outside remote result update");
  property p_oe_clk_low;
    $changed(bus_data_oe) |-> !bus_clk && $past(bus_clk, 2) == 1'b0;
  endproperty
  a_oe_clk_low: assert property (p_oe_clk_low)
    else $error("data driver changed while bus clock high");
  sequence s_ack;
    $rose(bus_data_oe) ##1 bus_data_oe [*4];
  endsequence
  property p_halt;
    s_ack |=> !conv_busy;
  endproperty
  a_halt: assert property (p_halt)
    else $error("conversion running while addressed");
  property p_od_low;
    !alarm_out_n && !overtemp_out_n && !bus_data_out;
  endproperty
  a_od_low: assert property (p_od_low)
    else $error("open drain value not low");
  c_ot: cover property ($rose(overtemp_oe));
  c_alarm: cover property ($rose(alarm_oe));
  c_zone: cover property ($fell(converting_remote));
  c_ack: cover property (s_ack);
endmodule
bind tzs_supervisor tzs_props #(
  .LOCAL_CONV_CYCLES(LOCAL_CONV_CYCLES),
  .REMOTE_CONV_CYCLES(REMOTE_CONV_CYCLES)
) i_props (
  .clock(clock),
  .resetn(resetn),
  .bus_clk(bus_clk),
  .bus_data_out(bus_data_out),
  .bus_data_oe(bus_data_oe),
  .alarm_out_n(alarm_out_n),
  .alarm_oe(alarm_oe),
  .overtemp_out_n(overtemp_out_n),
  .overtemp_oe(overtemp_oe),
  .converting_remote(converting_remote),
  .conv_busy(conv_busy)
);
`default_nettype wire

/* test/tb_top.sv */
// self-checking bench for the two-zone thermal supervisor
`timescale 1ns/100ps
`default_nettype none
`include "tzs_map.vh"
`define CHK(nm, ex, ac) \
  begin \
    samples_checked++; \
    if ((ac) !== (ex)) begin \
      num_errors++; \
      $display("[ERR] %s exp %h got %h", nm, ex, ac); \
    end \
  end
module tb_top;
  localparam logic [6:0] DEV = {`TZS_ADDR_HI, 1'b1};
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic strap = 1'b1;
  logic fault = 1'b0;
  logic [7:0] loc_adc = 8'h25;
  logic [7:0] rem_adc = 8'hE7;
  logic [7:0] q;
  logic k;
  wire scl, host_oe, sda, d_out, d_oe, al_n, al_oe, ot_n, ot_oe;
  wire cv_rem, busy;
  int num_errors = 0;
  int samples_checked = 0;
  logic [7:0] cm [6] = '{8'h02, 8'h03, 8'h12, 8'h13, 8'h22, 8'h23};
  logic [7:0] df [6] = '{8'h4C, 8'h51, 8'h5C, 8'h61, 8'h5C, 8'h61};
  logic [7:0] nv [6] = '{8'h20, 8'h30, 8'h40, 8'h50, 8'h60, 8'h70};
  int dq [4] = '{1, 2, 4, 6};
  always #2.5 clock = ~clock;
  // pulled-up data wire
  assign sda = ~(host_oe | d_oe);
  tzs_supervisor #(.LOCAL_CONV_CYCLES(20), .REMOTE_CONV_CYCLES(40)) i_dut (
    .clock(clock), .resetn(resetn), .bus_clk(scl), .bus_data_in(sda),
    .bus_data_out(d_out), .bus_data_oe(d_oe),
    .address_select_input(strap), .local_adc_value(loc_adc),
    .remote_adc_value(rem_adc), .remote_sense_fault(fault),
    .alarm_out_n(al_n), .alarm_oe(al_oe), .overtemp_out_n(ot_n),
    .overtemp_oe(ot_oe), .converting_remote(cv_rem), .conv_busy(busy)
  );
  tzs_host i_host (.clock(clock), .sda(sda), .scl(scl), .sda_oe(host_oe));
  // ==========================================================
  // tasks
  task stop_test;
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task idle(input int n);
    repeat (n) @(negedge clock);
  endtask
  task wr(input logic [7:0] c, input logic [7:0] d);
    i_host.wr(DEV, c, d, k);
    `CHK("write ack", 1'b0, k)
  endtask
  task rd(input logic [7:0] c, input logic [7:0] e);
    i_host.rd(DEV, c, q, k);
    `CHK("read ack", 1'b0, k)
    `CHK("read data", e, q)
  endtask
  // waits for the end of one remote conversion
  task rdone;
    int i, j;
    for (i = 0; i < 400 && cv_rem !== 1'b1; i++) @(negedge clock);
    for (j = 0; j < 400 && cv_rem !== 1'b0; j++) @(negedge clock);
    if (i >= 400 || j >= 400) begin
      num_errors++;
      stop_test;
    end
  endtask
  task conv2;
    rdone;
    rdone;
    idle(5);
  endtask
  // restart from shutdown and count remote results until alarm moves
  task fq(input logic [1:0] c, input logic [7:0] t, input logic lv,
          input int dp);
    int n;
    wr(8'h01, {3'h0, c, 3'h1});
    rem_adc = t;
    wr(8'h01, {3'h0, c, 3'h0});
    n = 0;
    while (n < 8 && al_oe !== lv) begin
      rdone;
      idle(5);
      n++;
    end
    `CHK("queue depth", dp, n)
  endtask
  // ==========================================================
  // main sequence
  initial begin
    idle(5);
    resetn = 1'b1;
    idle(6);
    rd(`TZS_REG_CONTROL, 8'h00);
    for (int i = 0; i < 6; i++) rd(cm[i], df[i]);
    for (int i = 0; i < 6; i++) begin
      wr(cm[i], nv[i]);
      rd(cm[i], nv[i]);
    end
    i_host.rx(DEV, q, k);
    `CHK("receive ack", 1'b0, k)
    `CHK("receive byte", 8'h70, q)
    i_host.rd(DEV ^ 7'h01, 8'h01, q, k);
    `CHK("other address nack", 1'b1, k)
    idle(200);
    rd(`TZS_REG_LOCAL_RESULT, 8'h25);
    rd(`TZS_REG_REMOTE_RESULT, 8'hE7);
    rd(`TZS_REG_CONTROL, 8'h00);
    wr(`TZS_REG_CONTROL, 8'h01);
    fault = 1'b1;
    idle(300);
    `CHK("busy in shutdown", 1'b0, busy)
    `CHK("overtemp in shutdown", 1'b0, ot_oe)
    rd(`TZS_REG_REMOTE_RESULT, 8'hE7);
    wr(`TZS_REG_CONTROL, 8'h00);
    rdone;
    idle(5);
    `CHK("fault overtemp", 1'b1, ot_oe)
    `CHK("fault alarm", 1'b1, al_oe)
    rd(`TZS_REG_REMOTE_RESULT, `TZS_FULL_SCALE);
    rd(`TZS_REG_CONTROL, 8'hC0);
    wr(`TZS_REG_CONTROL, 8'h01);
    fault = 1'b0;
    rem_adc = 8'h10;
    idle(300);
    `CHK("alarm held", 1'b1, al_oe)
    `CHK("overtemp held", 1'b1, ot_oe)
    wr(`TZS_REG_CONTROL, 8'h00);
    rdone;
    idle(5);
    `CHK("overtemp release", 1'b0, ot_oe)
    `CHK("alarm release", 1'b0, al_oe)
    for (int i = 0; i < 4; i++) begin
      fq(i[1:0], 8'h55, 1'b1, dq[i]);
      fq(i[1:0], 8'h10, 1'b0, dq[i]);
    end
    wr(`TZS_REG_CONTROL, 8'h02);
    rem_adc = 8'h55;
    conv2;
    `CHK("event alarm", 1'b1, al_oe)
    rem_adc = 8'h48;
    conv2;
    `CHK("alarm latched", 1'b1, al_oe)
    rd(`TZS_REG_LOCAL_HYST, 8'h20);
    `CHK("alarm read clear", 1'b0, al_oe)
    rem_adc = 8'h55;
    conv2;
    `CHK("no repeated over", 1'b0, al_oe)
    rem_adc = 8'h10;
    conv2;
    `CHK("under event", 1'b1, al_oe)
    wr(`TZS_REG_CONTROL, 8'h03);
    `CHK("shutdown clear", 1'b0, al_oe)
    rd(`TZS_REG_CONTROL, 8'h03);
    rem_adc = 8'h55;
    wr(`TZS_REG_CONTROL, 8'h06);
    conv2;
    `CHK("masked alarm", 1'b0, al_oe)
    rd(`TZS_REG_CONTROL, 8'h46);
    stop_test;
  end
endmodule
`default_nettype wire
